// ===== verilog/cfs_top.sv
// AXI4-Lite register front end of the CAN status and event flag block
`include "cfs_consts.svh"
`default_nettype none
// Operation
// - Bits 13..8 show FIFO write pointer
// - Bits 5..0 show next buffer to read
// - Unimplemented status/flag/enable bits read zero
// - Bit 13 follows transmitter bus-off state
// - Bit 12 follows transmitter error-passive state
// - Bit 11 follows receiver error-passive state
// - Bit 10 follows transmitter warning state
// - Bit 9 follows receiver warning state
// - Bit 8 is either warning state
// - Flags set by hardware, cleared writing zero
// - Bit 7 set on invalid message
// - Bit 6 set on bus wake-up activity
// - Bit 5 set when error indicators rise
// - Bit 3 set on FIFO almost full
// - Bit 2 set on receive overflow
// - Bit 1 set on receive buffer event
// - Bit 0 set on transmit buffer event
// - Enable bits match flags, reset zero
// - Enable bits 15..8 read zero
module cfs_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // FIFO pointers from the buffer manager
  input  wire logic [5:0]        fifo_write_pointer,
  input  wire logic [5:0]        fifo_next_read_pointer,
  // Error states from the protocol engine
  input  wire logic              tx_bus_off_state,
  input  wire logic              tx_error_passive_state,
  input  wire logic              rx_error_passive_state,
  input  wire logic              tx_warning_state,
  input  wire logic              rx_warning_state,
  // One-cycle event pulses
  input  wire logic              invalid_message_evt,
  input  wire logic              wakeup_activity_evt,
  input  wire logic              queue_almost_full_evt,
  input  wire logic              rx_overflow_evt,
  input  wire logic              rx_buffer_evt,
  input  wire logic              tx_buffer_evt,
  // Module interrupt request
  output logic                   irq
);
  // ****************************************
  // Declarations
  // ****************************************
  cfs_flag_if fl ();                   // Flag bank traffic
  logic [5:0]        state_bits;       // Error-state indicators
  logic              error_rise;       // Indicator went active
  logic [7:0]        enable_r;         // Event enable register
  logic              aw_held_r;        // Write address taken
  logic [ADDR_W-1:0] awaddr_r;         // Held write address
  logic              w_held_r;         // Write data taken
  logic [31:0]       wdata_r;          // Held write data
  logic [3:0]        wstrb_r;          // Held byte strobes
  logic              bvalid_r;         // Write response pending
  logic [1:0]        bresp_r;          // Write response code
  logic              rvalid_r;         // Read data pending
  logic [31:0]       rdata_r;          // Read data
  logic [1:0]        rresp_r;          // Read response code
  logic              irq_r;            // Registered interrupt
  logic              wr_fire;          // Both halves of a write held
  logic              rd_fire;          // Read address accepted
  cfs_pkg::cfs_reg_t wr_sel;           // Register targeted by write
  cfs_pkg::cfs_reg_t rd_sel;           // Register targeted by read
  logic [15:0]       rd_word;          // Read multiplexer output
  logic              flag_wr;          // Write to flag byte lane

  // Address decode shared by read and write paths
  function automatic cfs_pkg::cfs_reg_t reg_sel(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_W'(`CFS_OFS_FIFO):   reg_sel = cfs_pkg::CFS_REG_FIFO;
      ADDR_W'(`CFS_OFS_FLAG):   reg_sel = cfs_pkg::CFS_REG_FLAG;
      ADDR_W'(`CFS_OFS_ENABLE): reg_sel = cfs_pkg::CFS_REG_ENABLE;
      default:                  reg_sel = cfs_pkg::CFS_REG_NONE;
    endcase
  endfunction

  // ****************************************
  // Sub-blocks
  // ****************************************
  cfs_state_mon u_mon (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .tx_bus_off_state       (tx_bus_off_state),
    .tx_error_passive_state (tx_error_passive_state),
    .rx_error_passive_state (rx_error_passive_state),
    .tx_warning_state       (tx_warning_state),
    .rx_warning_state       (rx_warning_state),
    .state_bits             (state_bits),
    .error_rise             (error_rise)
  );

  cfs_flag_bank u_bank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fl      (fl.bank)
  );

  // ****************************************
  // Event and clear vectors
  // ****************************************
  assign fl.evt = {invalid_message_evt,
                   wakeup_activity_evt,
                   error_rise,
                   1'b0,
                   queue_almost_full_evt,
                   rx_overflow_evt,
                   rx_buffer_evt,
                   tx_buffer_evt};
  assign wr_sel  = reg_sel(awaddr_r);
  assign wr_fire = aw_held_r & w_held_r;
  assign flag_wr = wr_fire & wstrb_r[0] & (wr_sel == cfs_pkg::CFS_REG_FLAG);
  // Only zeros in written data clear; ones leave flags alone
  assign fl.clr  = flag_wr ? ~wdata_r[7:0] : 8'h00;

  // ****************************************
  // Write channel
  // ****************************************
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // Hold address and data until both arrived, then answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `CFS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // Both halves present: retire them and respond
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (wr_sel == cfs_pkg::CFS_REG_NONE) ?
                     `CFS_RESP_SLVERR : `CFS_RESP_OKAY;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Enable register, byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r <= `CFS_RST_ENABLE;
    end else if (wr_fire && wstrb_r[0] &&
                 wr_sel == cfs_pkg::CFS_REG_ENABLE) begin
      enable_r <= wdata_r[7:0] & `CFS_EVT_MASK;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  assign rd_sel  = reg_sel(s_axi_araddr);
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Read multiplexer, unused bits forced low
  always_comb begin
    rd_word = 16'h0000;
    case (rd_sel)
      cfs_pkg::CFS_REG_FIFO: begin
        rd_word[`CFS_WPTR_MSB:`CFS_WPTR_LSB] = fifo_write_pointer;
        rd_word[`CFS_RPTR_MSB:`CFS_RPTR_LSB] = fifo_next_read_pointer;
      end
      cfs_pkg::CFS_REG_FLAG: begin
        rd_word = {2'h0, state_bits, fl.flags};
      end
      cfs_pkg::CFS_REG_ENABLE: begin
        rd_word = {8'h00, enable_r};
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // Capture read data on address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `CFS_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {16'h0000, rd_word};
      rresp_r  <= (rd_sel == cfs_pkg::CFS_REG_NONE) ?
                  `CFS_RESP_SLVERR : `CFS_RESP_OKAY;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(fl.flags & enable_r);
    end
  end

  assign irq = irq_r;

  // ****************************************
  // Assertions
  // ****************************************
  a_wptr_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_sel == cfs_pkg::CFS_REG_FIFO |=>
      s_axi_rdata[13:8] == $past(fifo_write_pointer))
    else $error("FIFO write pointer misread");

  a_rptr_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_sel == cfs_pkg::CFS_REG_FIFO |=>
      s_axi_rdata[5:0] == $past(fifo_next_read_pointer) &&
      s_axi_rdata[15:14] == 2'h0 && s_axi_rdata[7:6] == 2'h0)
    else $error("FIFO next read pointer misread");

  a_unused_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    fl.flags[4] == 1'b0 && enable_r[4] == 1'b0 &&
    (!s_axi_rvalid || s_axi_rdata[31:16] == 16'h0000))
    else $error("Unimplemented bit not zero");

  a_busoff_track: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 state_bits[5] == $past(tx_bus_off_state))
    else $error("Bus-off indicator wrong");

  a_warn_any: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_bits[0] == (state_bits[2] | state_bits[1]))
    else $error("Any-warning indicator wrong");

  a_flag_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    flag_wr && fl.evt == 8'h00 |=>
      fl.flags == ($past(fl.flags) & $past(wdata_r[7:0])))
    else $error("Flag write did not clear by zeros");

  a_event_sets: assert property (
    @(posedge aclk) disable iff (!aresetn)
    fl.evt != 8'h00 |=>
      (fl.flags & $past(fl.evt)) == ($past(fl.evt) & `CFS_EVT_MASK))
    else $error("Event failed to set its flag");

  a_err_on_rise: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(state_bits[5]) || $rose(state_bits[0]) |=> fl.flags[5])
    else $error("Error flag not set by indicator");

  a_enable_reset: assert property (
    @(posedge aclk)
    $past(!aresetn) |-> enable_r == 8'h00 && !irq)
    else $error("Enable bits not cleared by reset");

  a_irq_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 irq == $past(|(fl.flags & enable_r)))
    else $error("Interrupt does not follow enabled flags");

  a_txpass_track: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 state_bits[4] == $past(tx_error_passive_state))
    else $error("Transmit passive indicator wrong");

  a_rxpass_track: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 state_bits[3] == $past(rx_error_passive_state))
    else $error("Receive passive indicator wrong");

  a_txwarn_track: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 state_bits[2] == $past(tx_warning_state))
    else $error("Transmit warning indicator wrong");

  a_rxwarn_track: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 state_bits[1] == $past(rx_warning_state))
    else $error("Receive warning indicator wrong");

  a_flag_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_sel == cfs_pkg::CFS_REG_FLAG |=>
      s_axi_rdata[15:14] == 2'h0 && s_axi_rdata[4] == 1'b0 &&
      s_axi_rdata[13:8] == $past(state_bits))
    else $error("Flag register misread");

  a_enable_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_sel == cfs_pkg::CFS_REG_ENABLE |=>
      s_axi_rdata[15:8] == 8'h00 && s_axi_rdata[7:0] == $past(enable_r))
    else $error("Enable register misread");

  a_lane_ignore: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_fire && !wstrb_r[0] |=> $stable(enable_r))
    else $error("Enable changed without byte lane 0");
endmodule
`default_nettype wire

// ===== verilog/cfs_consts.svh
// Offsets, field positions and reset values of the CAN status/flag block
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH
// Register byte offsets on the AXI4-Lite bus
`define CFS_OFS_FIFO     12'h000
`define CFS_OFS_FLAG     12'h004
`define CFS_OFS_ENABLE   12'h008
// Field positions in the 16-bit registers
`define CFS_WPTR_MSB     13
`define CFS_WPTR_LSB     8
`define CFS_RPTR_MSB     5
`define CFS_RPTR_LSB     0
// Implemented event flag / enable bits (bit 4 is absent)
`define CFS_EVT_MASK     8'hEF
// Event bit positions
`define CFS_BIT_INVALID  7
`define CFS_BIT_WAKE     6
`define CFS_BIT_ERROR    5
`define CFS_BIT_ALMOST   3
`define CFS_BIT_OVERFLOW 2
`define CFS_BIT_RXBUF    1
`define CFS_BIT_TXBUF    0
// Reset values
`define CFS_RST_ENABLE   8'h00
`define CFS_RST_FLAGS    8'h00
`define CFS_RST_STATE    6'h00
// AXI responses
`define CFS_RESP_OKAY    2'h0
`define CFS_RESP_SLVERR  2'h2
`endif

// ===== verilog/cfs_pkg.sv
// Types shared by the CAN status/flag block
`default_nettype none
package cfs_pkg;
  // Register selected by a bus address
  typedef enum logic [1:0] {
    CFS_REG_FIFO,
    CFS_REG_FLAG,
    CFS_REG_ENABLE,
    CFS_REG_NONE
  } cfs_reg_t;
endpackage
`default_nettype wire

// ===== verilog/cfs_flag_if.sv
// Link between the register front end and the event flag bank
`default_nettype none
interface cfs_flag_if;
  logic [7:0] evt;    // One-cycle set requests per flag
  logic [7:0] clr;    // One-cycle clear requests per flag
  logic [7:0] flags;  // Current sticky flags
  modport ctl  (output evt, output clr, input flags);
  modport bank (input evt, input clr, output flags);
endinterface
`default_nettype wire

// ===== verilog/cfs_flag_bank.sv
// Sticky event flags: set by hardware, cleared by writing zero
`include "cfs_consts.svh"
`default_nettype none
module cfs_flag_bank (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Flag traffic
  cfs_flag_if.bank  fl
);
  logic [7:0] flag_r;  // Flag storage
  localparam logic [7:0] MASK = `CFS_EVT_MASK;

  // ****************************************
  // One flip-flop per flag, bit 4 held at 0
  // ****************************************
  for (genvar i = 0; i < 8; i++) begin : g_flag
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_r[i] <= 1'b0;
      end else if (!MASK[i]) begin
        flag_r[i] <= 1'b0;
      end else begin
        // Set beats clear in the same cycle
        flag_r[i] <= fl.evt[i] | (flag_r[i] & ~fl.clr[i]);
      end
    end
  end

  assign fl.flags = flag_r;
endmodule
`default_nettype wire

// ===== verilog/cfs_state_mon.sv
// Error-state indicators and the error event they raise
`include "cfs_consts.svh"
`default_nettype none
module cfs_state_mon (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Raw states from the protocol engine
  input  wire logic       tx_bus_off_state,
  input  wire logic       tx_error_passive_state,
  input  wire logic       rx_error_passive_state,
  input  wire logic       tx_warning_state,
  input  wire logic       rx_warning_state,
  // Registered indicators, bit 5 bus-off down to bit 0 any warning
  output logic [5:0]      state_bits,
  // Pulse when any indicator becomes active
  output logic            error_rise
);
  logic [5:0] sts_r;    // Indicators as read by software
  logic [5:0] sts_d_r;  // Previous indicators for edge detection

  // ****************************************
  // Capture of the indicators
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_r   <= `CFS_RST_STATE;
      sts_d_r <= `CFS_RST_STATE;
    end else begin
      sts_r   <= {tx_bus_off_state,
                  tx_error_passive_state,
                  rx_error_passive_state,
                  tx_warning_state,
                  rx_warning_state,
                  tx_warning_state | rx_warning_state};
      sts_d_r <= sts_r;
    end
  end

  assign state_bits = sts_r;
  // Any indicator going active raises the error event
  assign error_rise = |(sts_r & ~sts_d_r);
endmodule
`default_nettype wire

// ===== verif/cfs_can_node.sv
// Far-side stand-in: CAN engine state levels, pointers and event pulses
`default_nettype none
module cfs_can_node (
  // Clock
  input  wire logic       aclk,
  // Requests from the bench
  input  wire logic [5:0] req_wptr,
  input  wire logic [5:0] req_rptr,
  input  wire logic [4:0] req_state,
  input  wire logic [5:0] req_evt,
  // Levels and pulses toward the block
  output logic [5:0]      wptr,
  output logic [5:0]      rptr,
  output logic [4:0]      state,
  output logic [5:0]      evt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Launch everything on the node's own edge, one cycle after the request
  always_ff @(posedge aclk) begin
    wptr  <= req_wptr;
    rptr  <= req_rptr;
    state <= req_state;
    evt   <= req_evt;
  end
endmodule
`default_nettype wire

// ===== verif/test_can_fifo_status_irq_flags.sv
// Self-checking bench of the CAN status and event flag block
`include "cfs_consts.svh"
`default_nettype none
module test_can_fifo_status_irq_flags;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Signals
  // ****************
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0]  wstrb, strb;  // strb: byte lanes offered by wr
  logic [1:0]  bresp, rresp, b_r, r_r;
  logic [5:0]  req_wptr, req_rptr, req_evt, wptr, rptr, evt;
  logic [4:0]  req_state, state;
  int          mismatches, checked, cycles;
  // Table row: address, write data, read back, response
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic [1:0]  s;
  } cfs_row_t;
  cfs_row_t rows [7];
  int epos [6] = '{0, 1, 2, 3, 6, 7};  // Flag bit of each event input
  // Clock of 10 ns
  always #5 aclk = ~aclk;
  // Far side
  cfs_can_node node (.aclk(aclk), .req_wptr(req_wptr), .req_rptr(req_rptr),
    .req_state(req_state), .req_evt(req_evt), .wptr(wptr), .rptr(rptr),
    .state(state), .evt(evt));
  cfs_top DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fifo_write_pointer(wptr), .fifo_next_read_pointer(rptr),
    .tx_bus_off_state(state[4]), .tx_error_passive_state(state[3]),
    .rx_error_passive_state(state[2]), .tx_warning_state(state[1]),
    .rx_warning_state(state[0]), .invalid_message_evt(evt[5]),
    .wakeup_activity_evt(evt[4]), .queue_almost_full_evt(evt[3]),
    .rx_overflow_evt(evt[2]), .rx_buffer_evt(evt[1]),
    .tx_buffer_evt(evt[0]), .irq(irq));
  // ****************
  // Tasks
  // ****************
  // Compare and count
  task check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Closing report
  task results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cycle ceiling against a hang
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      results();
    end
  end
  task idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write with an optional event pulse landing on the update edge
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [5:0] ev,
          output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'h1; wdata <= d; wstrb <= strb;
    wvalid <= 1'h1; bready <= 1'h1; req_evt <= ev;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      req_evt <= 6'h00;
      if (awvalid && awready === 1'h1) begin
        aw_ok = 1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready === 1'h1) begin
        w_ok = 1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask
  // Read one word
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  // One-cycle event request
  task pulse(input logic [5:0] m);
    @(posedge aclk);
    req_evt <= m;
    @(posedge aclk);
    req_evt <= 6'h00;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
    strb = 4'hF;
    req_wptr = 0; req_rptr = 0; req_state = 0; req_evt = 0;
    mismatches = 0; checked = 0; cycles = 0;
    rows[0] = '{`CFS_OFS_ENABLE, 32'hFFFFFFFF, 32'h000000EF, `CFS_RESP_OKAY};
    rows[1] = '{`CFS_OFS_ENABLE, 32'h00005A5A, 32'h0000004A, `CFS_RESP_OKAY};
    rows[2] = '{`CFS_OFS_ENABLE, 32'h00000000, 32'h00000000, `CFS_RESP_OKAY};
    rows[3] = '{`CFS_OFS_FIFO, 32'hFFFFFFFF, 32'h00000000, `CFS_RESP_OKAY};
    rows[4] = '{`CFS_OFS_FLAG, 32'hFFFFFFFF, 32'h00000000, `CFS_RESP_OKAY};
    rows[5] = '{12'h00C, 32'hFFFFFFFF, 32'h00000000, `CFS_RESP_SLVERR};
    rows[6] = '{12'hFFC, 32'h0000FFFF, 32'h00000000, `CFS_RESP_SLVERR};
    idle(3);
    aresetn <= 1'h1;
    // Reset values of all three registers
    rd(`CFS_OFS_FIFO, rd_d, r_r);
    check(rd_d, 32'h0);
    rd(`CFS_OFS_FLAG, rd_d, r_r);
    check(rd_d, 32'h0);
    rd(`CFS_OFS_ENABLE, rd_d, r_r);
    check(rd_d, 32'h0);
    $display("reset values done");
    // Table of register accesses
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d, 6'h00, b_r);
      check({30'h0, b_r}, {30'h0, rows[k].s});
      rd(rows[k].a, rd_d, r_r);
      check(rd_d, rows[k].r);
      check({30'h0, r_r}, {30'h0, rows[k].s});
    end
    $display("register table done");
    // Pointer fields at both ends of the buffer range
    for (int k = 0; k < 3; k++) begin
      @(posedge aclk);
      req_wptr <= (k == 0) ? 6'h1F : (k == 1) ? 6'h00 : 6'h15;
      req_rptr <= (k == 0) ? 6'h00 : (k == 1) ? 6'h1F : 6'h0A;
      idle(3);
      rd(`CFS_OFS_FIFO, rd_d, r_r);
      check(rd_d, {18'h0, req_wptr, 2'h0, req_rptr});
    end
    $display("pointer fields done");
    // Each error state alone, with the error flag it raises
    for (int i = 0; i < 5; i++) begin
      @(posedge aclk);
      req_state <= 5'h01 << i;
      idle(5);
      rd(`CFS_OFS_FLAG, rd_d, r_r);
      check(rd_d, (((32'h2 << i) | ((i < 2) ? 32'h1 : 32'h0)) << 8)
                  | 32'h20);
      @(posedge aclk);
      req_state <= 5'h00;
      idle(4);
      wr(`CFS_OFS_FLAG, 32'h0, 6'h00, b_r);
      rd(`CFS_OFS_FLAG, rd_d, r_r);
      check(rd_d, 32'h0);
    end
    $display("error states done");
    // Each event sets its flag; ones leave it, a zero clears it
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i);
      idle(2);
      rd(`CFS_OFS_FLAG, rd_d, r_r);
      check(rd_d, 32'h1 << epos[i]);
      wr(`CFS_OFS_FLAG, 32'hFFFF, 6'h00, b_r);
      rd(`CFS_OFS_FLAG, rd_d, r_r);
      check(rd_d, 32'h1 << epos[i]);
      wr(`CFS_OFS_FLAG, 32'hFFFF ^ (32'h1 << epos[i]), 6'h00, b_r);
      rd(`CFS_OFS_FLAG, rd_d, r_r);
      check(rd_d, 32'h0);
    end
    $display("event flags done");
    // Interrupt follows enabled flags
    wr(`CFS_OFS_ENABLE, 32'h2, 6'h00, b_r);
    pulse(6'h02);
    idle(3);
    check({31'h0, irq}, 32'h1);
    wr(`CFS_OFS_ENABLE, 32'h0, 6'h00, b_r);
    idle(2);
    check({31'h0, irq}, 32'h0);
    wr(`CFS_OFS_ENABLE, 32'h2, 6'h00, b_r);
    idle(2);
    check({31'h0, irq}, 32'h1);
    wr(`CFS_OFS_FLAG, 32'h0, 6'h00, b_r);
    idle(2);
    check({31'h0, irq}, 32'h0);
    $display("interrupt done");
    // Event on the very edge of a clearing write survives
    wr(`CFS_OFS_FLAG, 32'h0, 6'h04, b_r);
    rd(`CFS_OFS_FLAG, rd_d, r_r);
    check(rd_d, 32'h4);
    $display("set over clear done");
    // Write without byte lane 0 leaves the enables alone
    strb = 4'hE;
    wr(`CFS_OFS_ENABLE, 32'hEF, 6'h00, b_r);
    strb = 4'hF;
    rd(`CFS_OFS_ENABLE, rd_d, r_r);
    check(rd_d, 32'h2);
    $display("byte lane done");
    // Reset in mid-run clears flags, enables and the request
    wr(`CFS_OFS_ENABLE, 32'hEF, 6'h00, b_r);
    @(posedge aclk);
    aresetn <= 1'h0;
    idle(3);
    aresetn <= 1'h1;
    rd(`CFS_OFS_ENABLE, rd_d, r_r);
    check(rd_d, 32'h0);
    rd(`CFS_OFS_FLAG, rd_d, r_r);
    check(rd_d, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("second reset done");
    results();
  end
endmodule
`default_nettype wire
